/* File: rtl/jrl_rx_end.sv */
// jrl_rx_end: receive data link layer, register port and lane alignment
// assumes: link words from jrl_tx_end on the same i_mclk;
// software holds a one-cycle read/write strobe port
//
// How it works
// - set power-down bit turns lane receiver off
// - equalizer field 01 low power, 00 normal
// - sync request is driven low to resync
// - four commas all lanes, release at lmfc
// - transmitter starts alignment at its own lmfc
// - link parameters programmed before link start
// - alignment multiframes end /A/, second opens /R/ /Q/
// - alignment ramp contents are not checked
// - alignment multiframe count programmable, default four
// - elastic buffers release all lanes together
// - data after last /A/ aligned to lmfc
// - scrambling only on octets after alignment
// - detect disparity, table, control, alignment, skew
// - bad alignment or skew forces resync
// - optional resync at error count threshold
// - short sync pulse per erroneous multiframe
// - link errors raise an interrupt event
// - lane fifo absorbs two cycles of drift
// - fifo empty and full readable per lane
// - fifo error enable, status, clear bit two
// - four octets per processing clock cycle
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`include "jrl_map.svh"
module jrl_rx_end #(
	parameter int LANES = 8,
	parameter int DEPTH = 16
) (
	input  wire logic                i_mclk,
	input  wire logic                i_reset,
	jrl_link_if.rx                   link,
	input  wire logic [11:0]         i_addr,
	input  wire logic [7:0]          i_wdata,
	input  wire logic                i_wr,
	input  wire logic                i_rd,
	output logic [7:0]               o_rdata,
	output logic                     o_irq,
	output logic [LANES-1:0]         o_lane_powerdown_mask,
	output logic [1:0]               o_equalizer_power_select,
	output logic [LANES*32-1:0]      o_data,
	output logic                     o_data_valid
);
	import jrl_pkg::*;

	initial
	begin
		if (LANES < 1 || LANES > 8 || DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0)
			$error("jrl_rx_end: LANES 1..8, DEPTH power of two >= 4");
	end

	typedef struct packed {
		jrl_rx_state_t        st;
		logic                 restart;
		logic                 sync_n;
		logic                 pulse;
		logic                 mf_err;
		logic [7:0]           lmfc;
		logic [7:0]           pos;
		logic [7:0]           irq_en;
		logic [7:0]           irq_st;
		logic [7:0]           pd;
		logic [7:0]           eq;
		logic [7:0]           ilas_mf;
		logic [7:0]           ctrl;
		logic [7:0]           thr;
		logic [7:0]           errcnt;
		logic [7:0]           mf_len;
		logic [7:0]           rdata;
		logic                 irq;
		logic [LANES*15-1:0]  scr;
		logic [LANES*32-1:0]  dout;
		logic                 dval;
	} jrl_rx_s_t;

	jrl_rx_s_t s, n;
	logic [LANES-1:0]    cgs_ok, done, bad, empty, full, ovf, pdm;
	logic [36:0]         word [LANES];

	//--------------------------------------------------------------
	// lanes
	//--------------------------------------------------------------
	assign pdm = s.pd[LANES-1:0];
	for (genvar g = 0; g < LANES; g++)
	begin : g_lane
		// depth must cover one multiframe plus drift
		jrl_lane #(.DEPTH(DEPTH)) u_lane (
			.i_mclk     (i_mclk),
			.i_reset    (i_reset),
			.i_restart  (s.restart),
			.i_pd       (pdm[g]),
			.i_valid    (link.lane_valid[g]),
			.i_data     (link.serial_lane_in[g*32 +: 32]),
			.i_k        (link.lane_k[g*4 +: 4]),
			.i_code_err (link.lane_disp_err[g] || link.lane_nit_err[g]),
			.i_ilas_mf  (s.ilas_mf),
			.i_pop      (n.dval),
			.o_cgs_ok   (cgs_ok[g]),
			.o_done     (done[g]),
			.o_bad_ilas (bad[g]),
			.o_empty    (empty[g]),
			.o_full     (full[g]),
			.o_ovf      (ovf[g]),
			.o_word     (word[g])
		);
	end

	//--------------------------------------------------------------
	// link state, errors and registers
	//--------------------------------------------------------------
	logic        edge_l, mf_end, werr, skew, resync;
	logic [46:0] sc;

	always_comb
	begin
		n = s;
		n.restart = 1'b0;
		n.pulse = 1'b0;
		n.dval = 1'b0;
		werr = 1'b0;
		skew = 1'b0;
		resync = 1'b0;
		sc = '0;
		edge_l = (s.lmfc == 8'h00);
		mf_end = (s.pos + 8'h01 >= s.mf_len);
		n.lmfc = (s.lmfc + 8'h01 >= s.mf_len) ? 8'h00 : s.lmfc + 8'h01;
		unique case (s.st)
			JRL_RX_CGS:
				if (&(cgs_ok | pdm) && !s.restart)
					n.st = JRL_RX_WAIT;
			JRL_RX_WAIT:
				if (edge_l)
					n.st = JRL_RX_ILAS;  // release on lmfc edge
			JRL_RX_ILAS:
			begin
				if (|(bad & ~pdm))
					resync = 1'b1;
				else if (&(done | pdm) && edge_l)
				begin
					// first user word lands on the lmfc edge
					n.st = JRL_RX_DATA;
					n.pos = 8'h00;
					n.mf_err = 1'b0;
				end
			end
			JRL_RX_DATA:
			begin
				n.dval = &(~empty | pdm);  // all lanes leave together
				if (n.dval)
				begin
					for (int i = 0; i < LANES; i++)
					begin
						if (!pdm[i])
						begin
							werr = werr || word[i][36];
							// /A/ off the multiframe end means skew
							skew = skew || (word[i][32] && !mf_end
								&& word[i][7:0] == `JRL_CH_A);
						end
						// descramble user data only, never alignment
						sc = jrl_scramble(word[i][31:0], s.scr[i*15 +: 15],
							1'b1);
						n.scr[i*15 +: 15] = sc[46:32];
						n.dout[i*32 +: 32] = s.ctrl[`JRL_CTRL_SCR] ?
							sc[31:0] : word[i][31:0];
					end
					n.pos = mf_end ? 8'h00 : s.pos + 8'h01;
					n.mf_err = mf_end ? 1'b0 : (s.mf_err || werr);
					n.pulse = mf_end && (s.mf_err || werr);
					if (werr && s.errcnt != 8'hff)
						n.errcnt = s.errcnt + 8'h01;
					if (skew)
						resync = 1'b1;
					if (s.ctrl[`JRL_CTRL_RESYNC] && n.errcnt >= s.thr)
					begin
						resync = 1'b1;
						n.errcnt = 8'h00;
					end
				end
			end
		endcase
		if (resync)
		begin
			n.st = JRL_RX_CGS;
			n.restart = 1'b1;
		end
		// low from reset until the lmfc edge after cgs, on resync, and for error pulses
		n.sync_n = (n.st == JRL_RX_ILAS || n.st == JRL_RX_DATA)
			&& !n.pulse;

		if (i_wr)
		begin
			unique case (i_addr)
				`JRL_OFS_IRQ_EN:  n.irq_en = i_wdata;
				`JRL_OFS_IRQ_ST:  n.irq_st = s.irq_st & ~i_wdata;
				`JRL_OFS_LANE_PD: n.pd = i_wdata;
				`JRL_OFS_EQ:      n.eq = i_wdata;
				`JRL_OFS_ILAS_MF: n.ilas_mf = i_wdata;
				`JRL_OFS_CTRL:    n.ctrl = i_wdata;
				`JRL_OFS_THRESH:  n.thr = i_wdata;
				`JRL_OFS_MF_LEN:  n.mf_len = i_wdata;
				default:          n.irq_en = s.irq_en;
			endcase
		end
		// set wins over a clear in the same cycle
		if (|ovf)
			n.irq_st[`JRL_IRQ_FIFO_BIT] = 1'b1;
		if (resync || werr)
			n.irq_st[`JRL_IRQ_LINK_BIT] = 1'b1;
		n.irq = |(n.irq_st & n.irq_en);

		n.rdata = 8'h00;
		if (i_rd)
		begin
			unique case (i_addr)
				`JRL_OFS_IRQ_EN:  n.rdata = s.irq_en;
				`JRL_OFS_IRQ_ST:  n.rdata = s.irq_st;
				`JRL_OFS_LANE_PD: n.rdata = s.pd;
				`JRL_OFS_EQ:      n.rdata = s.eq;
				`JRL_OFS_FIFO_LO: n.rdata = 8'(empty);
				`JRL_OFS_FIFO_HI: n.rdata = 8'(full);
				`JRL_OFS_ILAS_MF: n.rdata = s.ilas_mf;
				`JRL_OFS_CTRL:    n.rdata = s.ctrl;
				`JRL_OFS_THRESH:  n.rdata = s.thr;
				`JRL_OFS_ERRCNT:  n.rdata = s.errcnt;
				`JRL_OFS_STATE:   n.rdata = 8'(s.st);
				`JRL_OFS_MF_LEN:  n.rdata = s.mf_len;
				default:          n.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
		begin
			s <= '0;
			s.restart <= 1'b1;
			s.ilas_mf <= `JRL_RST_ILAS_MF;
			s.mf_len <= `JRL_RST_MF_LEN;
			s.thr <= `JRL_RST_THRESH;
			s.eq <= `JRL_RST_EQ;
		end
		else
			s <= n;
	end

	//--------------------------------------------------------------
	// outputs, one word of four octets per lane per cycle
	//--------------------------------------------------------------
	assign link.sync_request_out_n = s.sync_n;
	assign o_rdata = s.rdata;
	assign o_irq = s.irq;
	assign o_lane_powerdown_mask = pdm;
	assign o_equalizer_power_select = s.eq[`JRL_EQ_MSB:`JRL_EQ_LSB];
	assign o_data = s.dout;
	assign o_data_valid = s.dval;
endmodule : jrl_rx_end

/* File: common/jrl_map.svh */
// jrl_map.svh: register offsets, resets, field positions and counts
// assumes: included by bare name from package and modules
`ifndef JRL_MAP_SVH
`define JRL_MAP_SVH
`define JRL_OFS_IRQ_EN    12'h020
`define JRL_OFS_IRQ_ST    12'h024
`define JRL_OFS_LANE_PD   12'h201
`define JRL_OFS_EQ        12'h268
`define JRL_OFS_FIFO_LO   12'h30c
`define JRL_OFS_FIFO_HI   12'h30d
`define JRL_OFS_ILAS_MF   12'h478
`define JRL_OFS_CTRL      12'h480
`define JRL_OFS_THRESH    12'h481
`define JRL_OFS_ERRCNT    12'h482
`define JRL_OFS_STATE     12'h483
`define JRL_OFS_MF_LEN    12'h484
`define JRL_RST_ILAS_MF   8'h04
`define JRL_RST_MF_LEN    8'h08
`define JRL_RST_THRESH    8'h08
`define JRL_RST_EQ        8'h00
`define JRL_IRQ_LINK_BIT  0
`define JRL_IRQ_FIFO_BIT  2
`define JRL_CTRL_RESYNC   0
`define JRL_CTRL_SCR      1
`define JRL_EQ_MSB        7
`define JRL_EQ_LSB        6
`define JRL_CH_K          8'hbc
`define JRL_CH_R          8'h1c
`define JRL_CH_Q          8'h9c
`define JRL_CH_A          8'h7c
`define JRL_CH_F          8'hfc
`define JRL_RESYNC_CYC    2'h3
`define JRL_OCTETS        4
`endif

/* File: common/jrl_pkg.sv */
// jrl_pkg: state encodings and the shared scrambler
// assumes: jrl_map.svh on the include path
`include "jrl_map.svh"
package jrl_pkg;
	typedef enum logic [1:0] {
		JRL_RX_CGS  = 2'b00,
		JRL_RX_WAIT = 2'b01,
		JRL_RX_ILAS = 2'b10,
		JRL_RX_DATA = 2'b11
	} jrl_rx_state_t;

	typedef enum logic [1:0] {
		JRL_TX_CGS  = 2'b00,
		JRL_TX_ILAS = 2'b01,
		JRL_TX_DATA = 2'b10
	} jrl_tx_state_t;

	// self-synchronous 1 + x^14 + x^15, first octet in the top byte;
	// result is {next state, word}
	function automatic logic [46:0] jrl_scramble(input logic [31:0] d,
		input logic [14:0] st, input logic desc);
		logic [14:0] s;
		logic [31:0] r;
		logic        b;
		s = st;
		r = 32'h0;
		for (int i = 31; i >= 0; i--)
		begin
			b = d[i] ^ s[13] ^ s[14];
			r[i] = b;
			s = {s[13:0], desc ? d[i] : b};
		end
		return {s, r};
	endfunction : jrl_scramble
endpackage : jrl_pkg

/* File: common/jrl_link_if.sv */
// jrl_link_if: lanes and sync request between transmitter and receiver
// assumes: both ends on i_mclk; each lane word holds four octets
`timescale 1ns/1ps
interface jrl_link_if #(parameter int LANES = 8);
	logic                  sync_request_out_n;
	logic [LANES*32-1:0]   serial_lane_in;
	logic [LANES*4-1:0]    lane_k;
	logic [LANES-1:0]      lane_valid;
	logic [LANES-1:0]      lane_disp_err;
	logic [LANES-1:0]      lane_nit_err;

	modport rx (
		output sync_request_out_n,
		input  serial_lane_in,
		input  lane_k,
		input  lane_valid,
		input  lane_disp_err,
		input  lane_nit_err
	);

	modport tx (
		input  sync_request_out_n,
		output serial_lane_in,
		output lane_k,
		output lane_valid,
		output lane_disp_err,
		output lane_nit_err
	);
endinterface : jrl_link_if

/* File: rtl/jrl_lane.sv */
// jrl_lane: one lane's comma search, alignment count and elastic fifo
// assumes: words arrive first octet in the top byte, same clock
`timescale 1ns/1ps
`include "jrl_map.svh"
module jrl_lane #(parameter int DEPTH = 16) (
	input  wire logic        i_mclk,
	input  wire logic        i_reset,
	input  wire logic        i_restart,
	input  wire logic        i_pd,
	input  wire logic        i_valid,
	input  wire logic [31:0] i_data,
	input  wire logic [3:0]  i_k,
	input  wire logic        i_code_err,
	input  wire logic [7:0]  i_ilas_mf,
	input  wire logic        i_pop,
	output logic             o_cgs_ok,
	output logic             o_done,
	output logic             o_bad_ilas,
	output logic             o_empty,
	output logic             o_full,
	output logic             o_ovf,
	output logic [36:0]      o_word
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic          cgs_ok;
		logic          done;
		logic          bad;
		logic          want_rq;
		logic [7:0]    acnt;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0]   cnt;
		logic          ovf;
	} jrl_lane_s_t;

	jrl_lane_s_t s, n;
	logic [36:0] mem [DEPTH];
	logic        live, kword, a_end, push, unexp;

	always_comb
	begin
		n = s;
		n.ovf = 1'b0;
		live = i_valid && !i_pd;  // powered-down lane is ignored
		kword = (i_k == 4'hf) && (i_data == {4{`JRL_CH_K}});
		a_end = i_k[0] && (i_data[7:0] == `JRL_CH_A);
		unexp = (|i_k[3:1]) || (i_k[0] && i_data[7:0] != `JRL_CH_A
			&& i_data[7:0] != `JRL_CH_F);
		push = live && s.done;
		if (i_restart)
			n = '0;
		else if (live && !s.cgs_ok)
			n.cgs_ok = kword;  // one word is four commas in a row
		else if (live && !s.done && !kword)
		begin
			// second multiframe must open with /R/ then /Q/
			if (s.want_rq)
				n.bad = !(i_k[3:2] == 2'b11 && i_data[31:24] == `JRL_CH_R
					&& i_data[23:16] == `JRL_CH_Q);
			n.want_rq = 1'b0;
			// ramp contents in between are not checked
			if (a_end)
			begin
				n.acnt = s.acnt + 8'h01;
				n.want_rq = (s.acnt == 8'h00);
				n.done = (s.acnt + 8'h01 >= i_ilas_mf);
			end
		end
		if (!i_restart)
		begin
			if (push && s.cnt == (AW + 1)'(DEPTH))
				n.ovf = 1'b1;
			if (push && s.cnt != (AW + 1)'(DEPTH))
				n.wp = s.wp + 1'b1;
			if (i_pop && s.cnt != '0)
				n.rp = s.rp + 1'b1;
			n.cnt = s.cnt + (AW + 1)'(push && s.cnt != (AW + 1)'(DEPTH))
				- (AW + 1)'(i_pop && s.cnt != '0);
		end
	end

	// words after the final /A/ wait here until all lanes are ready
	always_ff @(posedge i_mclk)
	begin
		if (push && s.cnt != (AW + 1)'(DEPTH))
			mem[s.wp] <= {i_code_err || unexp, i_k, i_data};
	end

	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
			s <= '0;
		else
			s <= n;
	end

	assign o_cgs_ok = s.cgs_ok;
	assign o_done = s.done;
	assign o_bad_ilas = s.bad;
	assign o_empty = (s.cnt == '0);
	assign o_full = (s.cnt == (AW + 1)'(DEPTH));
	assign o_ovf = s.ovf;
	assign o_word = mem[s.rp];
endmodule : jrl_lane

/* File: rtl/jrl_tx_end.sv */
// jrl_tx_end: transmitter end, commas, alignment sequence and data
// assumes: same i_mclk as the receiver; parameters set before reset ends
`timescale 1ns/1ps
`include "jrl_map.svh"
module jrl_tx_end #(parameter int LANES = 8) (
	input  wire logic                i_mclk,
	input  wire logic                i_reset,
	jrl_link_if.tx                   link,
	input  wire logic [7:0]          i_mf_len,
	input  wire logic [7:0]          i_ilas_mf,
	input  wire logic                i_scr_en,
	input  wire logic [LANES*32-1:0] i_data,
	output logic                     o_streaming,
	output logic                     o_err_pulse
);
	import jrl_pkg::*;

	initial
	begin
		if (LANES < 1 || LANES > 8)
			$error("jrl_tx_end: LANES must be 1..8");
	end

	typedef struct packed {
		jrl_tx_state_t       st;
		logic                pend;
		logic [1:0]          low;
		logic [7:0]          lmfc;
		logic [7:0]          wpos;
		logic [7:0]          mfi;
		logic [LANES*32-1:0] data;
		logic [LANES*4-1:0]  k;
		logic [LANES*15-1:0] scr;
		logic                err;
	} jrl_tx_s_t;

	jrl_tx_s_t   s, n;
	logic [46:0] sc;
	logic        last_w;

	always_comb
	begin
		n = s;
		n.err = 1'b0;
		sc = '0;
		last_w = (s.wpos + 8'h01 >= i_mf_len);
		n.lmfc = (s.lmfc + 8'h01 >= i_mf_len) ? 8'h00 : s.lmfc + 8'h01;
		unique case (s.st)
			JRL_TX_CGS:
			begin
				n.data = {(LANES * `JRL_OCTETS){`JRL_CH_K}};
				n.k = '1;
				n.pend = s.pend || link.sync_request_out_n;
				if (n.pend && s.lmfc == 8'h00)
				begin
					n.st = JRL_TX_ILAS;  // own lmfc edge after release
					n.wpos = 8'h00;
					n.mfi = 8'h00;
				end
			end
			JRL_TX_ILAS:
			begin
				// alignment words carry the multiframe index and word position, not link parameters
				for (int i = 0; i < LANES; i++)
				begin
					n.data[i*32 +: 32] = {s.mfi[7:0], s.wpos, s.mfi, s.wpos};
					n.k[i*4 +: 4] = 4'h0;
					if (s.mfi == 8'h01 && s.wpos == 8'h00)
					begin
						n.data[i*32 + 16 +: 16] = {`JRL_CH_R, `JRL_CH_Q};
						n.k[i*4 + 2 +: 2] = 2'b11;
					end
					if (last_w)
					begin
						n.data[i*32 +: 8] = `JRL_CH_A;
						n.k[i*4] = 1'b1;
					end
				end
				n.wpos = last_w ? 8'h00 : s.wpos + 8'h01;
				if (last_w)
					n.mfi = s.mfi + 8'h01;
				if (last_w && s.mfi + 8'h01 >= i_ilas_mf)
					n.st = JRL_TX_DATA;
			end
			JRL_TX_DATA:
			begin
				n.k = '0;
				for (int i = 0; i < LANES; i++)
				begin
					// scrambler starts at first octet after alignment
					sc = jrl_scramble(i_data[i*32 +: 32], s.scr[i*15 +: 15],
						1'b0);
					n.scr[i*15 +: 15] = sc[46:32];
					n.data[i*32 +: 32] = i_scr_en ? sc[31:0] : i_data[i*32 +: 32];
				end
			end
			default:
				n.st = JRL_TX_CGS;
		endcase
		// a short low is an error report, a long low a resync
		if (s.st != JRL_TX_CGS)
		begin
			if (!link.sync_request_out_n)
			begin
				n.low = (s.low == `JRL_RESYNC_CYC) ? s.low : s.low + 2'h1;
				if (n.low == `JRL_RESYNC_CYC)
				begin
					n.st = JRL_TX_CGS;
					n.pend = 1'b0;
					n.low = 2'h0;
				end
			end
			else
			begin
				n.err = (s.low != 2'h0);
				n.low = 2'h0;
			end
		end
	end

	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
			s <= '0;
		else
			s <= n;
	end

	assign link.serial_lane_in = s.data;
	assign link.lane_k = s.k;
	assign link.lane_valid = {LANES{1'b1}};
	assign link.lane_disp_err = '0;
	assign link.lane_nit_err = '0;
	assign o_streaming = (s.st == JRL_TX_DATA);
	assign o_err_pulse = s.err;
endmodule : jrl_tx_end

/* File: verification/jrl_link_checker.sv */
// jrl_link_checker: assertions on the wire between both ends
// assumes: lane 0 stands for all lanes; counts match both ends
`timescale 1ns/1ps
`include "jrl_map.svh"
module jrl_link_checker #(
	parameter int LANES   = 8,
	parameter int MF_LEN  = 8,
	parameter int ILAS_MF = 4
) (
	input  wire logic                i_mclk,
	input  wire logic                i_reset,
	input  wire logic                sync_request_out_n,
	input  wire logic [LANES*32-1:0] serial_lane_in,
	input  wire logic [LANES*4-1:0]  lane_k,
	input  wire logic [LANES-1:0]    lane_valid,
	input  wire logic [LANES-1:0]    lane_disp_err,
	input  wire logic [LANES-1:0]    lane_nit_err
);
	logic [7:0] since_k;
	logic [7:0] mf_pos;
	logic [7:0] a_cnt;
	logic       have_a;
	logic       comma_all;
	logic       a_seen;

	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_reset);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	assign comma_all = (&lane_k) && (&lane_valid)
		&& serial_lane_in == {(LANES*4){`JRL_CH_K}};
	assign a_seen = lane_valid[0] && lane_k[0]
		&& serial_lane_in[7:0] == `JRL_CH_A;

	// saturating, so a release with no commas at all still shows
	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
		begin
			since_k <= 8'hff;
			mf_pos  <= 8'h00;
			a_cnt   <= 8'h00;
			have_a  <= 1'b0;
		end
		else
		begin
			since_k <= comma_all ? 8'h00
				: (since_k == 8'hff ? since_k : since_k + 8'h01);
			mf_pos  <= a_seen ? 8'h00 : mf_pos + 8'h01;
			have_a  <= sync_request_out_n && (a_seen || have_a);
			a_cnt   <= !sync_request_out_n ? 8'h00
				: (a_seen ? a_cnt + 8'h01 : a_cnt);
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	a_sync_after_reset: assert property ($fell(i_reset) |-> !sync_request_out_n)
		else $error("sync request high right after reset");
	a_release_commas: assert property ($rose(sync_request_out_n) |-> since_k <= 8'h0c)
		else $error("sync request released without recent commas");
	a_comma_word: assert property (lane_valid[0] && lane_k[3:0] == 4'hf |-> serial_lane_in[31:0] == {4{`JRL_CH_K}})
		else $error("all-control word is not four commas");
	a_ilas_start: assert property ($rose(sync_request_out_n) |-> ##[1:20] lane_k[3:0] != 4'hf)
		else $error("alignment sequence did not follow release");
	a_r_then_q: assert property (lane_valid[0] && lane_k[3] && serial_lane_in[31:24] == `JRL_CH_R |-> lane_k[2] && serial_lane_in[23:16] == `JRL_CH_Q)
		else $error("start marker not followed by parameter marker");
	a_mf_spacing: assert property (a_seen && have_a |-> mf_pos == 8'(MF_LEN - 1))
		else $error("alignment marker off the multiframe end");
	a_k_free_data: assert property (sync_request_out_n && a_cnt >= 8'(ILAS_MF) |-> lane_k[3:1] == 3'h0)
		else $error("control octet inside streaming data");
	a_resync_cgs: assert property ($fell(sync_request_out_n) ##1 !sync_request_out_n [*2] |-> ##[1:6] lane_k[3:0] == 4'hf)
		else $error("no return to commas after resync request");

	c_release: cover property ($rose(sync_request_out_n));
	c_mf_end: cover property (a_seen && have_a);
	c_stream: cover property (a_cnt == 8'(ILAS_MF));
	c_resync: cover property ($fell(sync_request_out_n));
endmodule : jrl_link_checker

/* File: verification/jesd_rx_link_layer_tb_top.sv */
// jesd_rx_link_layer_tb_top: both ends joined, registers and link run
// assumes: 10 MHz clock, eight lanes, mf length 8, four alignment mfs
`timescale 1ns/1ps
`include "jrl_map.svh"
module jesd_rx_link_layer_tb_top;
	typedef struct packed {
		logic [11:0] addr;
		logic [7:0]  wdata;
		logic [7:0]  rexp;
		logic [7:0]  pd;
		logic [1:0]  eq;
	} jrl_row_t;

	localparam int LANES = 8;
	localparam int LIMIT = 3000;
	// last row is unmapped: write ignored, read zero
	localparam jrl_row_t ROWS [6] = '{
		'{12'h020, 8'h05, 8'h05, 8'h00, 2'h0},
		'{12'h201, 8'ha5, 8'ha5, 8'ha5, 2'h0},
		'{12'h268, 8'h40, 8'h40, 8'ha5, 2'h1},
		'{12'h268, 8'h00, 8'h00, 8'ha5, 2'h0},
		'{12'h478, 8'h06, 8'h06, 8'ha5, 2'h0},
		'{12'h123, 8'h77, 8'h00, 8'ha5, 2'h0}};

	logic                i_mclk = 1'b0;
	logic                i_reset;
	logic [11:0]         i_addr;
	logic [7:0]          i_wdata;
	logic                i_wr;
	logic                i_rd;
	logic [7:0]          rdata;
	logic                irq;
	logic [LANES-1:0]    pd_mask;
	logic [1:0]          eq_sel;
	logic [LANES*32-1:0] rx_data;
	logic                rx_valid;
	logic [31:0]         tx_word = 32'h0;
	logic                scr_en = 1'b1;
	logic                streaming;
	logic [7:0]          d;
	logic [31:0]         prev;
	int                  cycles = 0;
	int                  mismatches = 0;
	int                  total_checks = 0;

	always #50 i_mclk = ~i_mclk;

	// ------------------------------------------------------------
	// both ends and the checker
	// ------------------------------------------------------------
	jrl_link_if #(.LANES(LANES)) u_jrl_link_if ();

	jrl_rx_end #(.LANES(LANES), .DEPTH(16)) u_jrl_rx_end (
		.i_mclk                   (i_mclk),
		.i_reset                  (i_reset),
		.link                     (u_jrl_link_if),
		.i_addr                   (i_addr),
		.i_wdata                  (i_wdata),
		.i_wr                     (i_wr),
		.i_rd                     (i_rd),
		.o_rdata                  (rdata),
		.o_irq                    (irq),
		.o_lane_powerdown_mask    (pd_mask),
		.o_equalizer_power_select (eq_sel),
		.o_data                   (rx_data),
		.o_data_valid             (rx_valid)
	);

	jrl_tx_end #(.LANES(LANES)) u_jrl_tx_end (
		.i_mclk      (i_mclk),
		.i_reset     (i_reset),
		.link        (u_jrl_link_if),
		.i_mf_len    (8'h08),
		.i_ilas_mf   (8'h04),
		.i_scr_en    (scr_en),
		.i_data      ({LANES{tx_word}}),
		.o_streaming (streaming),
		.o_err_pulse ()
	);

	jrl_link_checker #(.LANES(LANES), .MF_LEN(8), .ILAS_MF(4)) u_jrl_link_checker (
		.i_mclk             (i_mclk),
		.i_reset            (i_reset),
		.sync_request_out_n (u_jrl_link_if.sync_request_out_n),
		.serial_lane_in     (u_jrl_link_if.serial_lane_in),
		.lane_k             (u_jrl_link_if.lane_k),
		.lane_valid         (u_jrl_link_if.lane_valid),
		.lane_disp_err      (u_jrl_link_if.lane_disp_err),
		.lane_nit_err       (u_jrl_link_if.lane_nit_err)
	);

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic check(input logic [255:0] seen, input logic [255:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic reg_wr(input logic [11:0] a, input logic [7:0] v);
		@(posedge i_mclk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= v;
		@(posedge i_mclk);
		i_wr <= 1'b0;
	endtask : reg_wr

	task automatic reg_rd(input logic [11:0] a, output logic [7:0] v);
		@(posedge i_mclk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1;
		v = rdata;
	endtask : reg_rd

	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : stop_test

	// payload counts up so gaps show; every lane carries the same word
	always @(posedge i_mclk)
	begin
		tx_word <= tx_word + 32'h1;
		cycles <= cycles + 1;
		if (cycles == LIMIT)
		begin
			mismatches++;
			stop_test();
		end
	end

	// ------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------
	initial
	begin
		i_reset = 1'b1;
		i_addr = 12'h000;
		i_wdata = 8'h00;
		i_wr = 1'b0;
		i_rd = 1'b0;
		repeat (12) @(posedge i_mclk);
		i_reset <= 1'b0;
		@(posedge i_mclk);
		#1;
		check(u_jrl_link_if.sync_request_out_n, 1'b0);
		reg_rd(12'h478, d);
		check(d, `JRL_RST_ILAS_MF);
		reg_rd(12'h268, d);
		check(d, `JRL_RST_EQ);
		for (int i = 0; i < 6; i++)
		begin
			reg_wr(ROWS[i].addr, ROWS[i].wdata);
			reg_rd(ROWS[i].addr, d);
			check(d, ROWS[i].rexp);
			check(pd_mask, ROWS[i].pd);
			check(eq_sel, ROWS[i].eq);
		end
		// second reset mid-run must bring back defaults
		@(posedge i_mclk);
		i_reset <= 1'b1;
		repeat (3) @(posedge i_mclk);
		i_reset <= 1'b0;
		reg_wr(12'h480, 8'h02);
		reg_wr(12'h020, 8'h04);
		check(pd_mask, 8'h00);
		for (int n = 0; n < 300 && u_jrl_link_if.sync_request_out_n !== 1'b1; n++)
		begin
			@(posedge i_mclk);
			#1;
		end
		check(u_jrl_link_if.sync_request_out_n, 1'b1);
		for (int n = 0; n < 300 && rx_valid !== 1'b1; n++)
		begin
			@(posedge i_mclk);
			#1;
		end
		check(rx_valid, 1'b1);
		// one word skipped: descrambler state settles on it
		@(posedge i_mclk);
		#1;
		prev = rx_data[31:0];
		repeat (16)
		begin
			@(posedge i_mclk);
			#1;
			check(rx_valid, 1'b1);
			check(rx_data, {LANES{prev + 32'h1}});
			prev = prev + 32'h1;
		end
		reg_rd(12'h483, d);
		check(d, 8'h03);
		check(u_jrl_link_if.sync_request_out_n, 1'b1);
		reg_rd(12'h024, d);
		check(d, 8'h00);
		check(irq, 1'b0);
		check(streaming, 1'b1);
		// threshold zero with resync on: first data word forces resync
		reg_wr(12'h481, 8'h00);
		reg_wr(12'h480, 8'h03);
		reg_rd(12'h024, d);
		check(d, 8'h01);
		check(irq, 1'b0);
		reg_wr(12'h020, 8'h05);
		#1;
		check(irq, 1'b1);
		// scrambling off on both ends for the next link
		reg_wr(12'h480, 8'h00);
		scr_en <= 1'b0;
		reg_wr(12'h024, 8'h01);
		reg_rd(12'h024, d);
		check(d, 8'h00);
		check(irq, 1'b0);
		check(streaming, 1'b0);
		for (int k = 0; k < 300 && rx_valid !== 1'b1; k++)
		begin
			@(posedge i_mclk);
			#1;
		end
		check(rx_valid, 1'b1);
		prev = rx_data[31:0];
		@(posedge i_mclk);
		#1;
		check(rx_data, {LANES{prev + 32'h1}});
		check(u_jrl_link_if.sync_request_out_n, 1'b1);
		stop_test();
	end
endmodule : jesd_rx_link_layer_tb_top
